// >>> src/otpb_pkg.sv
package otpb_pkg;
  // Bank shape and clock
  localparam int NUM_FUSE = 7;
  localparam int CLK_HZ = 100_000_000;
  localparam int CNT_W = 23;
  // Discharge times in ms and in cycles
  localparam int DIS_LONG_MS = 70;
  localparam int DIS_SHORT_MS = 35;
  localparam int DIS_LONG_CYC = DIS_LONG_MS * (CLK_HZ / 1000);
  localparam int DIS_SHORT_CYC = DIS_SHORT_MS * (CLK_HZ / 1000);
  // Fuse image after reset, bytes 0 to 6
  localparam logic [7:0] FUSE_DEF [NUM_FUSE] = '{8'h11, 8'ha6, 8'ha6,
    8'hdc, 8'h9c, 8'ha5, 8'hc0};
  // Software-writable bits of each runtime byte
  localparam logic [7:0] CTL_WMASK [NUM_FUSE] = '{8'h1d, 8'hbf, 8'hbf,
    8'hff, 8'hbf, 8'hff, 8'h00};
  // Field positions
  localparam int ON_BIT = 0;
  localparam int SS_LSB = 2;
  localparam int DIS_BIT = 4;
  localparam int EN_BIT = 7;
  localparam int OVP_BIT = 6;
  localparam int SET_MSB = 5;
  localparam int LHS_LSB = 6;
  localparam int LLS_LSB = 4;
  localparam int SHS_LSB = 2;
  localparam int SLS_LSB = 0;
  localparam int ADDR_LSB = 1;
  // Code tables
  localparam logic [5:0] CURRENT_LIMIT_CODE_DEF_CODE = 6'h26;
  localparam logic [5:0] VOLTAGE_LIMIT_CODE_DEF_CODE = 6'h1c;
  localparam logic [5:0] CURRENT_LIMIT_CODE_MAX_CODE = 6'h33;
  localparam logic [5:0] VOLTAGE_LIMIT_CODE_MAX_CODE = 6'h38;
  localparam int CURRENT_LIMIT_CODE_STEP_MA = 39;
  localparam int VOLTAGE_LIMIT_CODE_STEP_100UV = 976;
  localparam int LINEAR_BASE_MA = 1200;
  localparam int LINEAR_STEP_MA = 300;
  localparam int SWITCH_BASE_MA = 2500;
  localparam int SWITCH_STEP_MA = 500;
  // Bus map, byte addresses
  localparam logic [7:0] FUSE_OFS = 8'h00;
  localparam logic [7:0] CTL_OFS = 8'h20;
  localparam logic [7:0] STAT_OFS = 8'h40;
  localparam logic [7:0] CMD_OFS = 8'h44;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {ST_LOAD, ST_DISCHARGE, ST_RUN} otpb_state_t;

  typedef struct packed {
    logic power_on;
    logic dis_short;
    logic [3:0] ss_mult;
    logic input_overvoltage_en;
    logic [6:0] bus_addr;
  } otpb_sys_t;

  typedef struct packed {
    logic limit_en;
    logic code_ok;
    logic active;
    logic [5:0] code;
    logic [15:0] value;
  } otpb_lim_t;

  typedef struct packed {
    logic [11:0] linear_high_side_limit;
    logic [11:0] linear_low_side_limit;
    logic [11:0] switcher_high_side_limit;
    logic [11:0] switcher_low_side_limit;
  } otpb_sw_t;
endpackage: otpb_pkg

// >>> src/otpb_top.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module otpb_top
  import otpb_pkg::*;
#(
  parameter int unsigned DIS_LONG_CYCLES = DIS_LONG_CYC,
  parameter int unsigned DIS_SHORT_CYCLES = DIS_SHORT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output otpb_sys_t sys_cfg,
  output otpb_lim_t heat_current_limit,
  output otpb_lim_t cool_current_limit,
  output otpb_lim_t heat_voltage_limit,
  output otpb_lim_t cool_voltage_limit,
  output otpb_sw_t switch_limits,
  output logic load_done,
  output logic discharging
);

  // Limit code decode into enable, range check and scaled value
  function automatic otpb_lim_t lim_dec(input logic [7:0] b,
    input logic [5:0] max_code, input int step);
    otpb_lim_t r;
    r.limit_en = b[EN_BIT];
    r.code = b[SET_MSB:0];
    r.code_ok = (b[SET_MSB:0] <= max_code);
    r.active = r.limit_en & r.code_ok;
    r.value = r.code_ok ? 16'((int'(b[SET_MSB:0]) + 1) * step) : 16'h0000;
    return r;
  endfunction: lim_dec

  logic [7:0] fuse_q [NUM_FUSE];
  logic [7:0] ctl_q [NUM_FUSE];
  otpb_state_t state_q;
  logic [2:0] idx_q;
  logic [CNT_W-1:0] cnt_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  otpb_sys_t sys_q;
  otpb_lim_t hi_q;
  otpb_lim_t ci_q;
  otpb_lim_t hv_q;
  otpb_lim_t cv_q;
  otpb_sw_t sw_q;

  // Write channel decode
  wire [2:0] wr_idx = awaddr_q[4:2];
  wire wr_fire = !awready_q && !wready_q && !bvalid_q;
  wire wr_in_fuse = (awaddr_q[7:5] == FUSE_OFS[7:5]) && (wr_idx < 3'd7);
  wire wr_in_ctl = (awaddr_q[7:5] == CTL_OFS[7:5]) && (wr_idx < 3'd7);
  wire wr_stat = (awaddr_q[7:2] == STAT_OFS[7:2]);
  wire wr_cmd = (awaddr_q[7:2] == CMD_OFS[7:2]);
  wire wr_ctl_ok = wr_in_ctl && (wr_idx != 3'd6) && (state_q != ST_LOAD);
  wire ctl_wr_en = wr_fire && wr_ctl_ok && wstrb_q[0];
  wire reload = wr_fire && wr_cmd && wstrb_q[0] && wdata_q[0];
  wire [1:0] wr_resp = (wr_ctl_ok || wr_cmd) ? RESP_OKAY :
    (wr_in_fuse || wr_in_ctl || wr_stat) ? RESP_SLVERR : RESP_DECERR;

  // Read channel decode
  wire [2:0] rd_idx = s_axi_araddr[4:2];
  wire ar_take = s_axi_arvalid && arready_q;
  wire rd_in_fuse = (s_axi_araddr[7:5] == FUSE_OFS[7:5]) && (rd_idx < 3'd7);
  wire rd_in_ctl = (s_axi_araddr[7:5] == CTL_OFS[7:5]) && (rd_idx < 3'd7);
  wire rd_stat = (s_axi_araddr[7:2] == STAT_OFS[7:2]);
  wire rd_cmd = (s_axi_araddr[7:2] == CMD_OFS[7:2]);
  wire [6:0] stat_bits = {!cv_q.code_ok, !hv_q.code_ok, !ci_q.code_ok,
    !hi_q.code_ok, sys_q.power_on, state_q == ST_DISCHARGE,
    state_q != ST_LOAD};
  wire [31:0] rd_word = rd_in_fuse ? {24'h000000, fuse_q[rd_idx]} :
    rd_in_ctl ? {24'h000000, ctl_q[rd_idx]} :
    rd_stat ? {25'h0000000, stat_bits} : 32'h00000000;
  wire [1:0] rd_resp = (rd_in_fuse || rd_in_ctl || rd_stat || rd_cmd) ?
    RESP_OKAY : RESP_DECERR;

  // Runtime byte fields feeding the outputs
  wire [7:0] sys_b = ctl_q[0];
  wire [7:0] sw_b = ctl_q[5];
  wire [1:0] ss_sel = sys_b[SS_LSB+1:SS_LSB];
  wire dis_sel = sys_b[DIS_BIT];
  wire on_sel = sys_b[ON_BIT];
  wire [CNT_W-1:0] dis_load = dis_sel ?
    CNT_W'(DIS_SHORT_CYCLES - 1) : CNT_W'(DIS_LONG_CYCLES - 1);
  wire last_load = (state_q == ST_LOAD) && (idx_q == 3'd6);

  // Fuse array holds the factory image, read-only over the bus
  // fuse image
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fuse_q <= FUSE_DEF;
    end
  end

  // Power-up copy, discharge wait, then run
  // load sequence
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_LOAD;
      idx_q <= 3'd0;
      cnt_q <= '0;
    end
    else if (reload)
    begin
      state_q <= ST_LOAD;
      idx_q <= 3'd0;
    end
    else
    begin
      case (state_q)
        ST_LOAD:
        begin
          idx_q <= idx_q + 3'd1;
          if (idx_q == 3'd6)
          begin
            state_q <= ST_DISCHARGE;
            cnt_q <= dis_load;
          end
        end
        ST_DISCHARGE:
        begin
          if (cnt_q == '0)
            state_q <= ST_RUN;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_RUN:
          state_q <= ST_RUN;
        default:
          state_q <= ST_LOAD;
      endcase
    end
  end

  // Runtime bytes: copied from fuses, then software may adjust them
  // fuse copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= '{default: 8'h00};
    end
    else if (state_q == ST_LOAD)
    begin
      ctl_q[idx_q] <= fuse_q[idx_q];
    end
    else if (ctl_wr_en)
    begin
      ctl_q[wr_idx] <= (ctl_q[wr_idx] & ~CTL_WMASK[wr_idx]) |
        (wdata_q[7:0] & CTL_WMASK[wr_idx]);
    end
  end

  // Write address and data are caught in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_resp;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Read answer registered one cycle after address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_resp;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Decoded configuration, registered for the outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_q <= '0;
      hi_q <= '0;
      ci_q <= '0;
      hv_q <= '0;
      cv_q <= '0;
      sw_q <= '0;
    end
    else
    begin
      sys_q.power_on <= (state_q == ST_RUN) && on_sel;
      sys_q.dis_short <= dis_sel;
      sys_q.ss_mult <= 4'(4'h1 << ss_sel);
      sys_q.input_overvoltage_en <= ctl_q[3][OVP_BIT];
      sys_q.bus_addr <= ctl_q[6][7:ADDR_LSB];
      hi_q <= lim_dec(ctl_q[1], CURRENT_LIMIT_CODE_MAX_CODE, CURRENT_LIMIT_CODE_STEP_MA);
      ci_q <= lim_dec(ctl_q[2], CURRENT_LIMIT_CODE_MAX_CODE, CURRENT_LIMIT_CODE_STEP_MA);
      hv_q <= lim_dec(ctl_q[3], VOLTAGE_LIMIT_CODE_MAX_CODE, VOLTAGE_LIMIT_CODE_STEP_100UV);
      cv_q <= lim_dec(ctl_q[4], VOLTAGE_LIMIT_CODE_MAX_CODE, VOLTAGE_LIMIT_CODE_STEP_100UV);
      sw_q.linear_high_side_limit <= 12'(LINEAR_BASE_MA +
        LINEAR_STEP_MA * int'(sw_b[LHS_LSB+1:LHS_LSB]));
      sw_q.linear_low_side_limit <= 12'(LINEAR_BASE_MA +
        LINEAR_STEP_MA * int'(sw_b[LLS_LSB+1:LLS_LSB]));
      sw_q.switcher_high_side_limit <= 12'(SWITCH_BASE_MA +
        SWITCH_STEP_MA * int'(sw_b[SHS_LSB+1:SHS_LSB]));
      sw_q.switcher_low_side_limit <= 12'(SWITCH_BASE_MA +
        SWITCH_STEP_MA * int'(sw_b[SLS_LSB+1:SLS_LSB]));
    end
  end

  // Port drive
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign sys_cfg = sys_q;
  assign heat_current_limit = hi_q;
  assign cool_current_limit = ci_q;
  assign heat_voltage_limit = hv_q;
  assign cool_voltage_limit = cv_q;
  assign switch_limits = sw_q;

  // Status flags registered from the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_done <= 1'b0;
      discharging <= 1'b0;
    end
    else
    begin
      load_done <= (state_q != ST_LOAD) && !reload;
      discharging <= (state_q == ST_DISCHARGE) && !reload;
    end
  end

  // Assertion helpers
  logic all_match;
  always_comb
  begin
    all_match = 1'b1;
    for (int i = 0; i < NUM_FUSE; i++)
      all_match = all_match && (ctl_q[i] == fuse_q[i]);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Load steps
  sequence s_load_end;
    last_load && !reload;
  endsequence
  sequence s_enter_dis;
    state_q == ST_DISCHARGE && cnt_q == $past(dis_load);
  endsequence

  a_load_copies: assert property (s_load_end |=> all_match)
    else $error("runtime bytes differ from fuses after load");
  a_dis_time_set: assert property (s_load_end |=> s_enter_dis)
    else $error("discharge count not loaded from time select");
  a_dis_ends_run: assert property (
    state_q == ST_DISCHARGE && cnt_q == '0 && !reload |=> state_q == ST_RUN)
    else $error("discharge did not end in run");
  a_ss_scale: assert property ($past(aresetn) |->
    sys_q.ss_mult == 4'(4'h1 << $past(ss_sel)))
    else $error("soft-start multiplier wrong");
  a_power_gate: assert property (
    sys_q.power_on |-> $past(state_q) == ST_RUN && $past(on_sel))
    else $error("power stage on outside run");
  a_limit_active: assert property (
    hi_q.active == (hi_q.limit_en && hi_q.code_ok) &&
    cv_q.active == (cv_q.limit_en && cv_q.code_ok))
    else $error("limit applied while disabled");
  a_enable_bits: assert property (
    ##1 ci_q.limit_en == $past(ctl_q[2][EN_BIT]) &&
    hv_q.limit_en == $past(ctl_q[3][EN_BIT]))
    else $error("limit enable not taken from bit 7");
  a_ovp_bit: assert property (
    ##1 sys_q.input_overvoltage_en == $past(ctl_q[3][OVP_BIT]))
    else $error("overvoltage enable not from bit 6");
  a_fuse_defaults: assert property (
    fuse_q[1][SET_MSB:0] == CURRENT_LIMIT_CODE_DEF_CODE &&
    fuse_q[2][SET_MSB:0] == CURRENT_LIMIT_CODE_DEF_CODE &&
    fuse_q[3][SET_MSB:0] == VOLTAGE_LIMIT_CODE_DEF_CODE &&
    fuse_q[4][SET_MSB:0] == VOLTAGE_LIMIT_CODE_DEF_CODE)
    else $error("setpoint defaults wrong");
  a_linear_limits: assert property ($past(aresetn) |->
    sw_q.linear_high_side_limit ==
    12'(LINEAR_BASE_MA + LINEAR_STEP_MA * int'($past(sw_b[7:6]))) &&
    sw_q.linear_low_side_limit ==
    12'(LINEAR_BASE_MA + LINEAR_STEP_MA * int'($past(sw_b[5:4]))))
    else $error("linear stage limit wrong");
  a_switch_limits: assert property ($past(aresetn) |->
    sw_q.switcher_high_side_limit ==
    12'(SWITCH_BASE_MA + SWITCH_STEP_MA * int'($past(sw_b[3:2]))) &&
    sw_q.switcher_low_side_limit ==
    12'(SWITCH_BASE_MA + SWITCH_STEP_MA * int'($past(sw_b[1:0]))))
    else $error("switcher limit wrong");
  a_bus_address: assert property (
    ##1 sys_q.bus_addr == $past(ctl_q[6][7:1]))
    else $error("bus address not from bits 7 to 1");
  // Zeroed reset image is not a table entry, so skip the first cycle
  a_current_limit_code_table: assert property ($past(aresetn) |->
    hi_q.code_ok == (hi_q.code <= 6'h33) && (!hi_q.code_ok ||
    hi_q.value == 16'(39 * (int'(hi_q.code) + 1))))
    else $error("current limit table wrong");
  a_voltage_limit_code_table: assert property ($past(aresetn) |->
    hv_q.code_ok == (hv_q.code <= 6'h38) && (!hv_q.code_ok ||
    hv_q.value == 16'(976 * (int'(hv_q.code) + 1))))
    else $error("voltage limit table wrong");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule: otpb_top

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import otpb_pkg::*;
  localparam int unsigned LONG_C = 20;
  localparam int unsigned SHORT_C = 10;
  localparam int LIM = 200;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  otpb_sys_t sys_cfg;
  otpb_lim_t heat_i;
  otpb_lim_t cool_i;
  otpb_lim_t heat_v;
  otpb_lim_t cool_v;
  otpb_sw_t sw_lim;
  logic load_done;
  logic discharging;
  int n_fail = 0;
  int cmp_count = 0;
  int dcnt;
  // Raise bready only once the response is showing
  bit b_late = 1'b0;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] v;
  // Expected fuse image built from the field defaults
  logic [7:0] fuse_exp [7] = '{8'h11, 8'ha6, 8'ha6, 8'hdc, 8'h9c, 8'ha5,
    8'hc0};
  logic [7:0] ctab [4] = '{8'hb3, 8'hb4, 8'h80, 8'h26};
  logic [7:0] vtab [4] = '{8'hb8, 8'hb9, 8'h1c, 8'hdc};

  otpb_top #(.DIS_LONG_CYCLES(LONG_C), .DIS_SHORT_CYCLES(SHORT_C)) u_otpb_top
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sys_cfg(sys_cfg), .heat_current_limit(heat_i),
    .cool_current_limit(cool_i), .heat_voltage_limit(heat_v),
    .cool_voltage_limit(cool_v), .switch_limits(sw_lim),
    .load_done(load_done), .discharging(discharging)
  );

  // Clock, 10 ns period
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Verdict and end of run
  task test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask: test_done

  task check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask: check

  task tmo_chk(input int n);
    if (n >= LIM)
    begin
      n_fail++;
      test_done();
    end
  endtask: tmo_chk

  // Expected limit output from a runtime byte
  function automatic otpb_lim_t lim_exp(input logic [7:0] b, input bit is_v);
    otpb_lim_t e;
    e.limit_en = b[7];
    e.code = b[5:0];
    e.code_ok = is_v ? (b[5:0] <= 6'h38) : (b[5:0] <= 6'h33);
    e.active = e.limit_en & e.code_ok;
    e.value = !e.code_ok ? 16'h0000 :
      is_v ? 16'((b[5:0] + 1) * 976) : 16'((b[5:0] + 1) * 39);
    return e;
  endfunction: lim_exp

  // Write: offer AW and W together, drop each when taken, wait for B
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] dat,
    input logic [3:0] s, output logic [1:0] resp);
    int n;
    bit aw_done;
    bit w_done;
    bit a_hit;
    bit w_hit;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, dat};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= !b_late;
    aw_done = 0;
    w_done = 0;
    for (n = 0; n < LIM && !(aw_done && w_done); n++)
    begin
      @(negedge aclk);
      a_hit = !aw_done && awready === 1'b1;
      w_hit = !w_done && wready === 1'b1;
      @(posedge aclk);
      if (a_hit)
        awvalid <= 1'b0;
      if (w_hit)
        wvalid <= 1'b0;
      aw_done = aw_done | a_hit;
      w_done = w_done | w_hit;
    end
    tmo_chk(n);
    for (n = 0; n < LIM; n++)
    begin
      @(negedge aclk);
      if (bvalid === 1'b1)
        break;
    end
    tmo_chk(n);
    resp = bresp;
    if (b_late)
    begin
      @(posedge aclk);
      bready <= 1'b1;
    end
    @(posedge aclk);
    bready <= 1'b0;
  endtask: axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat,
    output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < LIM; n++)
    begin
      @(negedge aclk);
      if (arready === 1'b1)
        break;
    end
    tmo_chk(n);
    @(posedge aclk);
    arvalid <= 1'b0;
    for (n = 0; n < LIM; n++)
    begin
      @(negedge aclk);
      if (rvalid === 1'b1)
        break;
    end
    tmo_chk(n);
    dat = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask: axi_rd

  // Accepted write, then let the outputs follow
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] dat);
    logic [1:0] resp;
    axi_wr(a, dat, 4'hf, resp);
    check(resp, RESP_OKAY);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask: wr_ok

  // Count discharge cycles until the power stage turns on
  task automatic run_wait(output int cnt);
    int n;
    cnt = 0;
    for (n = 0; n < LIM; n++)
    begin
      @(negedge aclk);
      if (discharging === 1'b1)
        cnt++;
      if (sys_cfg.power_on === 1'b1)
        break;
    end
    tmo_chk(n);
  endtask: run_wait

  initial
  begin
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    check({load_done, bvalid, rvalid, awready, sys_cfg}, {4'h1, 14'h0});
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    run_wait(dcnt);
    check(dcnt >= SHORT_C && dcnt <= SHORT_C + 1, 1'b1);
    check(load_done, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      axi_rd(8'(4 * i), d, r);
      check({r, d}, {RESP_OKAY, 24'h0, fuse_exp[i]});
      axi_rd(8'(8'h20 + 4 * i), d, r);
      check({r, d}, {RESP_OKAY, 24'h0, fuse_exp[i]});
    end
    check(sys_cfg, {1'b1, 1'b1, 4'h1, 1'b1, 7'h60});
    check(heat_i, lim_exp(8'ha6, 0));
    check(cool_i, lim_exp(8'ha6, 0));
    check(heat_v, lim_exp(8'hdc, 1));
    check(cool_v, lim_exp(8'h9c, 1));
    check(sw_lim, {12'd1800, 12'd1800, 12'd3000, 12'd3000});
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 2; k++)
      begin
        wr_ok(8'(8'h24 + 4 * k), ctab[i]);
        check(k ? cool_i : heat_i, lim_exp(ctab[i], 0));
      end
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 2; k++)
      begin
        wr_ok(8'(8'h2c + 4 * k), vtab[i]);
        check(k ? cool_v : heat_v, lim_exp(vtab[i], 1));
        if (k == 0)
          check(sys_cfg.input_overvoltage_en, vtab[i][6]);
      end
    for (int s = 0; s < 4; s++)
    begin
      v = {3'b000, s[0], s[1:0], 2'b01};
      wr_ok(8'h20, v);
      check({sys_cfg.ss_mult, sys_cfg.dis_short}, {4'(1 << s), v[4]});
      check(sys_cfg.power_on, 1'b1);
    end
    wr_ok(8'h20, 8'h10);
    check(sys_cfg.power_on, 1'b0);
    for (int j = 0; j < 4; j++)
    begin
      wr_ok(8'h34, {4{j[1:0]}});
      check(sw_lim, {{2{12'(1200 + 300 * j)}}, {2{12'(2500 + 500 * j)}}});
    end
    // Refused writes to a fuse byte and to the address byte
    axi_wr(8'h04, 8'h00, 4'hf, r);
    check(r, RESP_SLVERR);
    axi_rd(8'h04, d, r);
    check(d, 32'h000000a6);
    axi_wr(8'h38, 8'h00, 4'hf, r);
    check(r, RESP_SLVERR);
    repeat (2) @(negedge aclk);
    check(sys_cfg.bus_addr, 7'h60);
    // Late bready: response must stand until taken
    b_late = 1'b1;
    axi_wr(8'h80, 8'h55, 4'hf, r);
    b_late = 1'b0;
    check(r, RESP_DECERR);
    axi_rd(8'h80, d, r);
    check({r, d}, {RESP_DECERR, 32'h0});
    axi_wr(8'h24, 8'h00, 4'h0, r);
    check(r, RESP_OKAY);
    axi_rd(8'h24, d, r);
    check(d, 32'h00000026);
    axi_rd(8'h40, d, r);
    check(d[2:0], 3'h1);
    wr_ok(8'h44, 8'h01);
    run_wait(dcnt);
    check(dcnt >= SHORT_C && dcnt <= SHORT_C + 1, 1'b1);
    axi_rd(8'h24, d, r);
    check(d, 32'h000000a6);
    axi_rd(8'h20, d, r);
    check(d, 32'h00000011);
    axi_rd(8'h40, d, r);
    check(d[2:0], 3'h5);
    test_done();
  end
endmodule: tb_top
